/* File: sim/digital_output_timing_engine_bench.sv */
// Self-checking bench: drives the engine over Avalon-MM and judges its outputs.
// Assumes dote_engine, its checker and the output module model are compiled first.
`timescale 1ns/1ps
module digital_output_timing_engine_bench
  import dote_pkg::*;
;
  logic                          sys_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic [7:0]                    avs_address = 8'h00;
  logic                          avs_read = 1'b0;
  logic                          avs_write = 1'b0;
  logic [31:0]                   avs_writedata = DOTE_ZERO;
  logic [31:0]                   avs_readdata;
  logic                          avs_waitrequest;
  logic [DOTE_ENGINES-1:0]       start_trigger_in = 8'h00;
  logic [DOTE_ENGINES-1:0]       pause_trigger_in = 8'h00;
  logic [DOTE_ENGINES-1:0]       module_busy_in = 8'h00;
  logic [DOTE_ENGINES-1:0]       ext_strobe_in = 8'h00;
  logic [DOTE_ENGINES*32-1:0]    dout;
  logic [DOTE_ENGINES-1:0]       strobe_terminal;
  logic [DOTE_ENGINES-1:0]       start_terminal;
  logic [31:0]                   rdata;
  int                            mismatches = 0;
  int                            n_checks = 0;
  dote_engine uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .start_trigger_in, .pause_trigger_in,
    .ext_timebase_in(8'h00), .ext_strobe_in, .module_busy_in, .dout,
    .strobe_terminal, .start_terminal);
  dote_output_modules pm (.sys_clk, .rst_n, .dout, .strobe_terminal, .start_terminal);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access: hold the request until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    if (n >= 50) begin
      mismatches++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    rdata = DOTE_ZERO;
    while (rdata[b] !== 1'b1 && n < 100) begin
      bus(1'b0, DOTE_REG_STATUS, DOTE_ZERO);
      n++;
    end
    check(32'(rdata[b]), DOTE_ONE);
  endtask
  task automatic setup(input int e, input logic [31:0] ctrl, input logic [31:0] div);
    w(DOTE_REG_SEL, 32'(e));
    w(DOTE_REG_CTRL, ctrl);
    w(DOTE_REG_DIV, div);
  endtask
  task automatic t_regs();
    w(DOTE_REG_SEL, DOTE_ZERO);
    bus(1'b0, DOTE_REG_DIV, DOTE_ZERO);
    check(rdata, DOTE_DIV_RESET);
    bus(1'b0, 8'h40, DOTE_ZERO);
    check(rdata, DOTE_ZERO);
    $display("registers done");
  endtask
  task automatic t_finite();
    setup(0, 32'(DOTE_FINITE), 32'h0000_0004);
    w(DOTE_REG_COUNT, 32'h0000_0003);
    for (int i = 1; i <= 3; i++) begin
      w(DOTE_REG_DATA, 32'ha5a5_0000 + 32'(i));
    end
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    poll(DOTE_S_DONE);
    check(32'(pm.n_upd[0]), 32'h0000_0003);
    check(pm.last[0], 32'ha5a5_0003);
    check(dout[31:0], 32'ha5a5_0003);
    $display("finite done");
  endtask
  task automatic t_trigger();
    setup(1, 32'(1 << DOTE_C_TRIG_EN | 1 << DOTE_C_TRIG_FALL), 32'h0000_0002);
    w(DOTE_REG_DELAY, 32'h0000_0006);
    w(DOTE_REG_COUNT, DOTE_ONE);
    w(DOTE_REG_DATA, 32'h1234_5678);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    start_trigger_in[1] <= 1'b1;
    repeat (12) @(posedge sys_clk);
    check(32'(pm.n_upd[1]), DOTE_ZERO);
    check(32'(pm.n_start[1]), DOTE_ZERO);
    start_trigger_in[1] <= 1'b0;
    poll(DOTE_S_DONE);
    check(32'(pm.n_start[1]), DOTE_ONE);
    check(32'(pm.t_first[1] - pm.t_start[1]), 32'h0000_0008);
    check(pm.last[1], 32'h1234_5678);
    $display("trigger done");
  endtask
  task automatic t_modes();
    setup(2, 32'(DOTE_NOREGEN), 32'h0000_0002);
    w(DOTE_REG_DATA, 32'h0000_00aa);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    poll(DOTE_S_UNDER);
    setup(3, 32'(DOTE_ONBOARD), 32'h0000_0002);
    w(DOTE_REG_DATA, 32'h0000_00b0);
    w(DOTE_REG_DATA, 32'h0000_00b1);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    w(DOTE_REG_DATA, 32'h0000_00b2);
    poll(DOTE_S_LOCKED);
    check(32'(rdata[12:8]), 32'h0000_0002);
    check(32'(pm.last[3] == 32'h0000_00b0 || pm.last[3] == 32'h0000_00b1), DOTE_ONE);
    setup(5, 32'(DOTE_SINGLE), 32'h0000_0004);
    w(DOTE_REG_DATA, 32'h0000_00c5);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    poll(DOTE_S_LATE);
    check(pm.last[5], 32'h0000_00c5);
    $display("modes done");
  endtask
  task automatic t_refusals();
    w(DOTE_REG_SEL, 32'h0000_0004);
    w(DOTE_REG_MODULE, 32'h0000_0011);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    poll(DOTE_S_REJECT);
    check(32'(rdata[DOTE_S_RUN]), DOTE_ZERO);
    module_busy_in[6] <= 1'b1;
    w(DOTE_REG_SEL, 32'h0000_0006);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_DIRCFG));
    poll(DOTE_S_DIRERR);
    $display("refusals done");
  endtask
  task automatic pulse();
    ext_strobe_in[7] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    ext_strobe_in[7] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_pause();
    setup(7, 32'(DOTE_REGEN) | 32'(1 << DOTE_C_PAUSE_EN | 1 << DOTE_C_PAUSE_LOW
      | 1 << DOTE_C_EXT_STB), DOTE_ONE);
    w(DOTE_REG_DATA, 32'h0000_00d7);
    w(DOTE_REG_CMD, 32'(1 << DOTE_K_START));
    pulse();
    check(32'(pm.n_upd[7]), DOTE_ZERO);
    pause_trigger_in[7] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(32'(pm.n_upd[7]), DOTE_ZERO);
    pulse();
    check(32'(pm.n_upd[7]), DOTE_ONE);
    check(pm.last[7], 32'h0000_00d7);
    $display("pause done");
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_finite();
    t_trigger();
    t_modes();
    t_refusals();
    t_pause();
    stop_test();
  end
endmodule

/* File: sim/dote_engine_assertions.sv */
// Checker for the engine's bus handshake, reset state and output pulses.
// Assumes it is bound to dote_engine and sees only that module's ports.
`timescale 1ns/1ps
module dote_engine_assertions
  import dote_pkg::*;
#(
  parameter int WIDTH = DOTE_WIDTH
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_readdata,
  input wire logic                          avs_waitrequest,
  input wire logic [DOTE_ENGINES-1:0]       start_trigger_in,
  input wire logic [DOTE_ENGINES*WIDTH-1:0] dout,
  input wire logic [DOTE_ENGINES-1:0]       strobe_terminal,
  input wire logic [DOTE_ENGINES-1:0]       start_terminal
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence req_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence no_start_pulse;
    !$rose(start_terminal[1]) ##1 !$rose(start_terminal[1]);
  endsequence
  sequence one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_wait_answer: assert property (req_taken |=> one_wait)
    else $error("request not answered after one wait state");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  chk_readdata_holds: assert property (!avs_read && !avs_write |-> $stable(avs_readdata))
    else $error("read data changed while idle");
  chk_reset_clears: assert property (!$past(rst_n) |-> dout == '0 && start_terminal == '0)
    else $error("outputs not cleared by reset");
  chk_start_pulse: assert property ((start_terminal & $past(start_terminal)) == '0)
    else $error("start output pulse longer than one cycle");
  chk_dout_strobe: assert property ($changed(dout[WIDTH-1:0]) |-> $changed(strobe_terminal[0]))
    else $error("output word changed without an update strobe");
  chk_start_sync: assert property ($changed(start_trigger_in[1]) |=> no_start_pulse)
    else $error("start trigger used before synchronising");
endmodule
bind dote_engine dote_engine_assertions #(.WIDTH(WIDTH)) chk (.sys_clk, .rst_n, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .start_trigger_in, .dout, .strobe_terminal,
  .start_terminal);

/* File: sim/dote_output_modules.sv */
// Model of the output modules that take each engine's word on its update strobe.
// Assumes strobe outputs are left active high and dout is registered with them.
`timescale 1ns/1ps
module dote_output_modules
  import dote_pkg::*;
#(
  parameter int WIDTH = DOTE_WIDTH
) (
  input wire logic                          sys_clk,
  input wire logic                          rst_n,
  input wire logic [DOTE_ENGINES*WIDTH-1:0] dout,
  input wire logic [DOTE_ENGINES-1:0]       strobe_terminal,
  input wire logic [DOTE_ENGINES-1:0]       start_terminal
);
  int          cyc;
  int          n_upd   [DOTE_ENGINES];
  int          n_start [DOTE_ENGINES];
  int          t_start [DOTE_ENGINES];
  int          t_first [DOTE_ENGINES];
  logic [31:0] last    [DOTE_ENGINES];
  // Each strobe latches the engine's whole word, as a module would.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    for (int e = 0; e < DOTE_ENGINES; e++) begin
      if (rst_n && strobe_terminal[e] === 1'b1) begin
        if (n_upd[e] == 0) begin
          t_first[e] <= cyc;
        end
        n_upd[e] <= n_upd[e] + 1;
        last[e]  <= 32'(dout[e*WIDTH +: WIDTH]);
      end
      if (rst_n && start_terminal[e] === 1'b1) begin
        n_start[e] <= n_start[e] + 1;
        t_start[e] <= cyc;
      end
    end
  end
endmodule

/* File: verilog/dote_engine.sv */
// Eight output timing engines behind one Avalon-MM slave with waitrequest.
// Assumes trigger, pause, timebase and busy inputs arrive from pins asynchronously.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dote_engine
  import dote_pkg::*;
#(
  parameter int WIDTH     = DOTE_WIDTH,
  parameter int DEPTH_LOG = DOTE_DEPTH_LOG
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic [DOTE_ENGINES-1:0] start_trigger_in,
  input  wire logic [DOTE_ENGINES-1:0] pause_trigger_in,
  input  wire logic [DOTE_ENGINES-1:0] ext_timebase_in,
  input  wire logic [DOTE_ENGINES-1:0] ext_strobe_in,
  input  wire logic [DOTE_ENGINES-1:0] module_busy_in,
  output logic [DOTE_ENGINES*WIDTH-1:0] dout,
  output logic [DOTE_ENGINES-1:0]       strobe_terminal,
  output logic [DOTE_ENGINES-1:0]       start_terminal
);
  localparam int DEPTH = 1 << DEPTH_LOG;
  localparam logic [DEPTH_LOG:0] FULL_COUNT = (DEPTH_LOG+1)'(DEPTH);
  localparam logic [DEPTH_LOG-1:0] PTR_ONE  = DEPTH_LOG'(1);
  localparam logic [DEPTH_LOG:0]   LVL_ONE  = (DEPTH_LOG+1)'(1);

  typedef struct packed {
    logic [9:0]           ctrl;
    logic [31:0]          div;
    logic [31:0]          delay;
    logic [31:0]          count;
    logic [7:0]           modcfg;
    dote_state_type       state;
    logic [31:0]          timer;
    logic [31:0]          done_cnt;
    logic [DEPTH_LOG-1:0] wr_ptr;
    logic [DEPTH_LOG-1:0] rd_ptr;
    logic [DEPTH_LOG:0]   level;
    logic                 pending;
    logic                 hold;
    logic [7:0]           status;
    logic [WIDTH-1:0]     out;
    logic                 stb_q;
    logic                 start_q;
    logic [2:0]           trig_s;
    logic [2:0]           pause_s;
    logic [2:0]           tb_s;
    logic [2:0]           stb_s;
    logic [1:0]           busy_s;
  } dote_eng_type;

  logic [DOTE_SEL_BITS-1:0] sel;
  logic                     wait_q;
  logic [31:0]              rdata;
  logic [31:0]              eng_rd [DOTE_ENGINES];
  logic                     bus_req;

  assign bus_req = avs_read | avs_write;

  // One access per two cycles: waitrequest is high on the first cycle of a request.
  // Writes land at the edge where waitrequest is low, as the master sees it.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_q       <= 1'b1;
      sel          <= '0;
      avs_readdata <= DOTE_ZERO;
    end else begin
      wait_q <= !(bus_req && wait_q);
      if (bus_req && wait_q) begin
        avs_readdata <= rdata;
      end
      if (avs_write && !wait_q && avs_address == DOTE_REG_SEL) begin
        sel <= avs_writedata[DOTE_SEL_BITS-1:0];
      end
    end
  end
  assign avs_waitrequest = wait_q;

  always_comb begin
    rdata = eng_rd[sel];
    if (avs_address == DOTE_REG_SEL) begin
      rdata = {29'h0000_0000, sel};
    end
  end

  genvar g;
  generate
    for (g = 0; g < DOTE_ENGINES; g++) begin : gen_eng
      dote_eng_type     cur;
      dote_eng_type     nxt;
      logic [WIDTH-1:0] mem [DEPTH];
      logic             acc;
      logic             wr_data;
      logic             tb_tick;
      logic             ext_edge;
      logic             trig_edge;
      logic             paused;
      logic             pop;
      logic             stb_src;
      dote_mode_type    mode;

      assign acc      = avs_write && !wait_q && (sel == DOTE_SEL_BITS'(g));
      assign wr_data  = acc && avs_write && avs_address == DOTE_REG_DATA;
      assign mode     = dote_mode_type'(cur.ctrl[DOTE_C_MODE +: 3]);
      assign tb_tick  = cur.tb_s[1] & ~cur.tb_s[2];
      assign ext_edge = cur.stb_s[1] & ~cur.stb_s[2];
      assign trig_edge = cur.ctrl[DOTE_C_TRIG_FALL] ? (cur.trig_s[2] & ~cur.trig_s[1])
                                                    : (cur.trig_s[1] & ~cur.trig_s[2]);
      assign paused = cur.ctrl[DOTE_C_PAUSE_EN] &
                      (cur.pause_s[1] ^ cur.ctrl[DOTE_C_PAUSE_LOW]);

      always_comb begin
        eng_rd[g] = DOTE_ZERO;
        if (avs_address == DOTE_REG_CTRL) begin
          eng_rd[g] = {22'h00_0000, cur.ctrl};
        end else if (avs_address == DOTE_REG_DIV) begin
          eng_rd[g] = cur.div;
        end else if (avs_address == DOTE_REG_DELAY) begin
          eng_rd[g] = cur.delay;
        end else if (avs_address == DOTE_REG_COUNT) begin
          eng_rd[g] = cur.done_cnt;
        end else if (avs_address == DOTE_REG_STATUS) begin
          eng_rd[g] = {16'h0000, 3'h0, cur.level, cur.status};
        end else if (avs_address == DOTE_REG_MODULE) begin
          eng_rd[g] = {24'h00_0000, cur.modcfg};
        end
      end

      always_comb begin
        nxt = cur;
        pop = 1'b0;
        stb_src = 1'b0;
        nxt.trig_s  = {cur.trig_s[1:0], start_trigger_in[g]};
        nxt.pause_s = {cur.pause_s[1:0], pause_trigger_in[g]};
        nxt.tb_s    = {cur.tb_s[1:0], ext_timebase_in[g]};
        nxt.stb_s   = {cur.stb_s[1:0], ext_strobe_in[g]};
        nxt.busy_s  = {cur.busy_s[0], module_busy_in[g]};
        nxt.start_q = 1'b0;
        nxt.stb_q   = cur.ctrl[DOTE_C_STB_INV];
        if (acc && avs_write) begin
          if (avs_address == DOTE_REG_CTRL && cur.state == DOTE_IDLE) begin
            nxt.ctrl = avs_writedata[9:0];
          end else if (avs_address == DOTE_REG_DIV) begin
            nxt.div = (avs_writedata == DOTE_ZERO) ? DOTE_ONE : avs_writedata;
          end else if (avs_address == DOTE_REG_DELAY) begin
            nxt.delay = avs_writedata;
          end else if (avs_address == DOTE_REG_COUNT) begin
            nxt.count = avs_writedata;
          end else if (avs_address == DOTE_REG_MODULE) begin
            nxt.modcfg = avs_writedata[7:0];
          end else if (avs_address == DOTE_REG_CMD) begin
            if (avs_writedata[DOTE_K_CLEAR]) begin
              nxt.status[DOTE_S_UNDER]  = 1'b0;
              nxt.status[DOTE_S_LATE]   = 1'b0;
              nxt.status[DOTE_S_DIRERR] = 1'b0;
              nxt.status[DOTE_S_DONE]   = 1'b0;
            end
            if (avs_writedata[DOTE_K_DIRCFG]) begin
              if (cur.busy_s[1] || cur.state != DOTE_IDLE) begin
                nxt.status[DOTE_S_DIRERR] = 1'b1;
              end
            end
            if (avs_writedata[DOTE_K_START] && cur.state == DOTE_IDLE) begin
              if ((cur.modcfg[3:0] != 4'h0) && (cur.modcfg[7:4] != 4'h0)) begin
                nxt.status[DOTE_S_REJECT] = 1'b1;
              end else begin
                nxt.status[DOTE_S_REJECT] = 1'b0;
                nxt.status[DOTE_S_RUN]    = 1'b1;
                nxt.done_cnt = DOTE_ZERO;
                nxt.rd_ptr   = '0;
                nxt.state    = cur.ctrl[DOTE_C_TRIG_EN] ? DOTE_ARMED : DOTE_DELAY;
                nxt.timer    = cur.delay;
                nxt.status[DOTE_S_LOCKED] = (mode == DOTE_ONBOARD);
              end
            end
            if (avs_writedata[DOTE_K_STOP]) begin
              nxt.state = DOTE_IDLE;
              nxt.status[DOTE_S_RUN]    = 1'b0;
              nxt.status[DOTE_S_LOCKED] = 1'b0;
              nxt.level  = '0;
              nxt.wr_ptr = '0;
              nxt.rd_ptr = '0;
            end
          end
        end
        if (wr_data && !cur.status[DOTE_S_LOCKED] && cur.level != FULL_COUNT) begin
          nxt.wr_ptr = cur.wr_ptr + PTR_ONE;
          if (mode == DOTE_SINGLE) begin
            nxt.pending = 1'b1;
          end else begin
            nxt.level = cur.level + LVL_ONE;
          end
        end
        nxt.status[DOTE_S_FULL] = (nxt.level == FULL_COUNT);
        if (cur.state != DOTE_IDLE && (!cur.ctrl[DOTE_C_EXT_TB] || tb_tick)) begin
          if (cur.timer != DOTE_ZERO) begin
            nxt.timer = cur.timer - DOTE_ONE;
          end
        end
        case (cur.state)
          DOTE_IDLE: begin
          end
          DOTE_ARMED: begin
            if (trig_edge) begin
              nxt.start_q = 1'b1;
              nxt.state   = DOTE_DELAY;
              nxt.timer   = cur.delay;
            end
          end
          DOTE_DELAY: begin
            if (cur.ctrl[DOTE_C_EXT_STB] || cur.timer == DOTE_ZERO) begin
              nxt.state = DOTE_RUN;
              nxt.timer = DOTE_ZERO;
              nxt.hold  = 1'b0;
            end
          end
          DOTE_RUN: begin
            stb_src = cur.ctrl[DOTE_C_EXT_STB] ? ext_edge : (cur.timer == DOTE_ZERO);
            if (!cur.ctrl[DOTE_C_EXT_STB] && cur.timer == DOTE_ZERO) begin
              nxt.timer = cur.div - DOTE_ONE;
            end
            if (paused) begin
              nxt.hold      = 1'b1;
            end else if (cur.hold && !cur.ctrl[DOTE_C_EXT_STB]) begin
              nxt.hold  = 1'b0;
              nxt.timer = DOTE_ZERO;
            end else if (cur.hold && ext_edge) begin
              nxt.hold = 1'b0;
            end
            if (stb_src && !paused && (!cur.hold || cur.ctrl[DOTE_C_EXT_STB])) begin
              pop = 1'b1;
            end
          end
          default: begin
            nxt.state = DOTE_IDLE;
          end
        endcase
        if (pop) begin
          nxt.stb_q = !cur.ctrl[DOTE_C_STB_INV];
          if (mode == DOTE_SINGLE) begin
            if (!cur.pending) begin
              nxt.status[DOTE_S_LATE] = 1'b1;
            end
            nxt.out     = mem[cur.wr_ptr - PTR_ONE];
            nxt.pending = wr_data;
          end else if (cur.level == '0) begin
            if (mode == DOTE_NOREGEN) begin
              nxt.status[DOTE_S_UNDER] = 1'b1;
            end
          end else begin
            nxt.out      = mem[cur.rd_ptr];
            nxt.done_cnt = cur.done_cnt + DOTE_ONE;
            if (mode == DOTE_REGEN || mode == DOTE_ONBOARD) begin
              nxt.rd_ptr = (cur.rd_ptr + PTR_ONE == cur.wr_ptr) ? '0 : cur.rd_ptr + PTR_ONE;
            end else begin
              nxt.rd_ptr = cur.rd_ptr + PTR_ONE;
              nxt.level  = nxt.level - LVL_ONE;
            end
            if (mode == DOTE_FINITE && cur.done_cnt + DOTE_ONE == cur.count) begin
              nxt.state = DOTE_IDLE;
              nxt.status[DOTE_S_RUN]  = 1'b0;
              nxt.status[DOTE_S_DONE] = 1'b1;
            end
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          cur       <= '0;
          cur.div   <= DOTE_DIV_RESET;
          cur.state <= DOTE_IDLE;
        end else begin
          cur <= nxt;
        end
        if (wr_data && !cur.status[DOTE_S_LOCKED] && cur.level != FULL_COUNT) begin
          mem[cur.wr_ptr] <= avs_writedata[WIDTH-1:0];
        end
      end

      assign dout[g*WIDTH +: WIDTH] = cur.out;
      assign strobe_terminal[g]     = cur.stb_q;
      assign start_terminal[g]      = cur.start_q;
    end
  endgenerate
endmodule

/* File: verilog/dote_pkg.sv */
// Constants, register map and types for the digital output timing engine.
// Assumes a single 100 MHz clock and an Avalon-MM master with waitrequest.
package dote_pkg;
  localparam int          DOTE_ENGINES     = 8;
  localparam int          DOTE_WIDTH       = 32;
  localparam int          DOTE_DEPTH_LOG   = 4;
  localparam int          DOTE_SEL_BITS    = 3;
  localparam logic [7:0] DOTE_REG_CTRL    = 8'h00;
  localparam logic [7:0] DOTE_REG_DIV     = 8'h04;
  localparam logic [7:0] DOTE_REG_DELAY   = 8'h08;
  localparam logic [7:0] DOTE_REG_COUNT   = 8'h0c;
  localparam logic [7:0] DOTE_REG_DATA    = 8'h10;
  localparam logic [7:0] DOTE_REG_STATUS  = 8'h14;
  localparam logic [7:0] DOTE_REG_CMD     = 8'h18;
  localparam logic [7:0] DOTE_REG_MODULE  = 8'h1c;
  localparam logic [7:0] DOTE_REG_SEL     = 8'h20;
  localparam int          DOTE_C_MODE      = 0;
  localparam int          DOTE_C_EXT_TB    = 3;
  localparam int          DOTE_C_TRIG_EN   = 4;
  localparam int          DOTE_C_TRIG_FALL = 5;
  localparam int          DOTE_C_PAUSE_EN  = 6;
  localparam int          DOTE_C_PAUSE_LOW = 7;
  localparam int          DOTE_C_STB_INV   = 8;
  localparam int          DOTE_C_EXT_STB   = 9;
  localparam int          DOTE_K_START     = 0;
  localparam int          DOTE_K_STOP      = 1;
  localparam int          DOTE_K_CLEAR     = 2;
  localparam int          DOTE_K_DIRCFG    = 3;
  localparam int          DOTE_S_RUN       = 0;
  localparam int          DOTE_S_UNDER     = 1;
  localparam int          DOTE_S_LATE      = 2;
  localparam int          DOTE_S_REJECT    = 3;
  localparam int          DOTE_S_FULL      = 4;
  localparam int          DOTE_S_DIRERR    = 5;
  localparam int          DOTE_S_LOCKED    = 6;
  localparam int          DOTE_S_DONE      = 7;
  localparam logic [31:0] DOTE_DIV_RESET   = 32'h0000_0064;
  localparam logic [31:0] DOTE_ZERO        = 32'h0000_0000;
  localparam logic [31:0] DOTE_ONE         = 32'h0000_0001;
  localparam logic [31:0] DOTE_DEAD        = 32'h0000_0000;
  typedef enum logic [2:0] {
    DOTE_FINITE   = 3'h0,
    DOTE_REGEN    = 3'h1,
    DOTE_ONBOARD  = 3'h2,
    DOTE_NOREGEN  = 3'h3,
    DOTE_SINGLE   = 3'h4
  } dote_mode_type;
  typedef enum logic [1:0] {
    DOTE_IDLE  = 2'b00,
    DOTE_ARMED = 2'b01,
    DOTE_DELAY = 2'b11,
    DOTE_RUN   = 2'b10
  } dote_state_type;
endpackage
